// file: design/tws_device.sv
// two-wire slave port of the power management unit
// Summary of operation
// - one data bit per serial clock pulse
// - sample on clock high, hold data high
// - change data only while clock low
// - data change mid-transaction abandons the transaction
// - start, any number of bytes, stop
// - eight bits, MSB first, then acknowledge
// - only the master makes start and stop
// - data falling while clock high is start
// - data rising while clock high is stop
// - busy from start until after stop
// - repeated start accepted as fresh start
// - master gives ninth clock for acknowledge
// - transmitter releases data during acknowledge clock
// - receiver holds data low to acknowledge
// - own address, slave only, never drives clock
`timescale 1ns/100ps
module tws_device #(
  parameter logic [6:0] OWN_ADDR = tws_pkg::OWN_ADDR_DEF,
  parameter int DEPTH = tws_pkg::RX_DEPTH,
  parameter int WIDTH = tws_pkg::BYTE_W,
  parameter int BUSY_HOLD = tws_pkg::BUSY_HOLD_CYC
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  tws_if.dev bus,
  output logic [WIDTH-1:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  input wire logic [WIDTH-1:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic busy_out,
  output logic abort_out
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int HW = $clog2(BUSY_HOLD + 1);

  ////////////////////////////////////////////////////////////////////////////
  // line sampling

  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;

  // a level counts only once the last two stages agree
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], bus.scl};
      sda_sync <= {sda_sync[1:0], bus.sda};
      if (scl_sync[2] == scl_sync[1]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[2] == sda_sync[1]) begin
        sda_f <= sda_sync[2];
      end
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  wire scl_rise = scl_f & ~scl_q;
  wire scl_fall = ~scl_f & scl_q;
  wire scl_high = scl_f & scl_q;
  wire start_det = scl_high & sda_q & ~sda_f;
  wire stop_det = scl_high & ~sda_q & sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // receive buffer

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0] count;
  logic push;
  logic [WIDTH-1:0] push_data;
  wire pop = rx_valid_out & rx_ready_in;
  wire fifo_space = count < CW'(DEPTH);
  wire [CW-1:0] wr_idx = pop ? count - CW'(1) : count;
  wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);

  // head always sits in mem[0] so the output is a plain register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      count <= '0;
      rx_valid_out <= 1'b0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && CW'(i) == wr_idx) begin
          mem[i] <= push_data;
        end else if (pop && i < DEPTH - 1) begin
          mem[i] <= mem[(i + 1) % DEPTH];
        end
      end
      count <= next_count;
      rx_valid_out <= next_count != '0;
    end
  end

  assign rx_data_out = mem[0];

  ////////////////////////////////////////////////////////////////////////////
  // byte engine

  tws_pkg::tws_dev_state_t state;
  tws_pkg::tws_dev_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic sda_oe_n;
  logic next_sda_oe_n;
  logic rw;
  logic next_rw;
  logic acked;
  logic next_acked;
  logic tx_take;

  wire [7:0] tx_byte = tx_valid_in ? tx_data_in : tws_pkg::IDLE_FILL;
  wire in_frame = state != tws_pkg::TWS_D_IDLE && state != tws_pkg::TWS_D_IGNORE;
  // mid-byte abort
  // a legal stop or restart sits in the first high phase of a byte
  wire abort_det = (start_det | stop_det) & in_frame & (cnt > 4'h1);
  wire addr_hit = sh[7:1] == OWN_ADDR;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_sda_oe_n = sda_oe_n;
    next_rw = rw;
    next_acked = acked;
    push = 1'b0;
    push_data = sh;
    tx_take = 1'b0;
    if (start_det) begin
      next_state = tws_pkg::TWS_D_ADDR;
      next_cnt = '0;
      next_sda_oe_n = 1'b1;
    end else if (stop_det) begin
      next_state = tws_pkg::TWS_D_IDLE;
      next_cnt = '0;
      next_sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      case (state)
        tws_pkg::TWS_D_ADDR, tws_pkg::TWS_D_WR_BYTE: begin
          next_sh = {sh[6:0], sda_f};
          next_cnt = cnt + 4'h1;
        end
        tws_pkg::TWS_D_RD_ACK: begin
          next_acked = ~sda_f;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        tws_pkg::TWS_D_ADDR: begin
          if (cnt == tws_pkg::BYTE_BITS) begin
            next_state = addr_hit ? tws_pkg::TWS_D_ADDR_ACK : tws_pkg::TWS_D_IGNORE;
            next_sda_oe_n = ~addr_hit;
            next_rw = sh[0];
          end
        end
        tws_pkg::TWS_D_WR_BYTE: begin
          if (cnt == tws_pkg::BYTE_BITS) begin
            push = fifo_space;
            next_state = fifo_space ? tws_pkg::TWS_D_WR_ACK : tws_pkg::TWS_D_IGNORE;
            next_sda_oe_n = ~fifo_space;
          end
        end
        tws_pkg::TWS_D_ADDR_ACK, tws_pkg::TWS_D_WR_ACK, tws_pkg::TWS_D_RD_ACK: begin
          next_sda_oe_n = 1'b1;
          next_cnt = '0;
          if ((state == tws_pkg::TWS_D_ADDR_ACK && rw) ||
              (state == tws_pkg::TWS_D_RD_ACK && acked)) begin
            tx_take = tx_valid_in;
            next_sda_oe_n = tx_byte[7];
            next_sh = {tx_byte[6:0], 1'b0};
            next_cnt = 4'h1;
            next_state = tws_pkg::TWS_D_RD_BYTE;
          end else if (state == tws_pkg::TWS_D_RD_ACK) begin
            next_state = tws_pkg::TWS_D_IGNORE;
          end else begin
            next_state = tws_pkg::TWS_D_WR_BYTE;
          end
        end
        tws_pkg::TWS_D_RD_BYTE: begin
          if (cnt == tws_pkg::BYTE_BITS) begin
            next_sda_oe_n = 1'b1;
            next_cnt = '0;
            next_state = tws_pkg::TWS_D_RD_ACK;
          end else begin
            next_sda_oe_n = sh[7];
            next_sh = {sh[6:0], 1'b0};
            next_cnt = cnt + 4'h1;
          end
        end
        default: begin
          next_sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= tws_pkg::TWS_D_IDLE;
      cnt <= '0;
      sh <= '0;
      sda_oe_n <= 1'b1;
      rw <= 1'b0;
      acked <= 1'b0;
      tx_ready_out <= 1'b0;
      abort_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      sda_oe_n <= next_sda_oe_n;
      rw <= next_rw;
      acked <= next_acked;
      tx_ready_out <= tx_take;
      abort_out <= abort_det;
    end
  end

  assign bus.dev_sda_oe_n = sda_oe_n;
  assign bus.dev_sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // bus occupancy

  logic [HW-1:0] hold_cnt;
  logic hold_run;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_out <= 1'b0;
      hold_cnt <= '0;
      hold_run <= 1'b0;
    end else if (start_det) begin
      busy_out <= 1'b1;
      hold_run <= 1'b0;
    end else if (stop_det) begin
      hold_cnt <= HW'(BUSY_HOLD);
      hold_run <= 1'b1;
    end else if (hold_run) begin
      hold_cnt <= hold_cnt - HW'(1);
      if (hold_cnt == HW'(1)) begin
        busy_out <= 1'b0;
        hold_run <= 1'b0;
      end
    end
  end

endmodule

// file: design/tws_pkg.sv
// shared constants and state types for the two-wire slave port and its master
package tws_pkg;

  localparam int CLK_PERIOD_NS = 20;
  // bus stays busy this long after a stop
  localparam int BUSY_HOLD_NS = 1300;
  localparam int BUSY_HOLD_CYC = (BUSY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // serial clock period made by the master
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  localparam int BYTE_W = 8;
  localparam int RX_DEPTH = 2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // sent when the user has no read byte ready
  localparam logic [7:0] IDLE_FILL = 8'hFF;
  // arbitrary value
  localparam logic [6:0] OWN_ADDR_DEF = 7'h3C;

  localparam logic [1:0] PH_DRIVE = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  typedef enum logic [2:0] {
    TWS_D_IDLE = 3'h0,
    TWS_D_ADDR = 3'h1,
    TWS_D_ADDR_ACK = 3'h2,
    TWS_D_WR_BYTE = 3'h3,
    TWS_D_WR_ACK = 3'h4,
    TWS_D_RD_BYTE = 3'h5,
    TWS_D_RD_ACK = 3'h6,
    TWS_D_IGNORE = 3'h7
  } tws_dev_state_t;

  typedef enum logic [2:0] {
    TWS_H_IDLE = 3'h0,
    TWS_H_HOLD = 3'h1,
    TWS_H_START = 3'h2,
    TWS_H_BIT = 3'h3,
    TWS_H_STOP = 3'h4
  } tws_host_state_t;

endpackage

// file: design/tws_if.sv
// two-wire bus wiring between master and slave port, open-drain resolution
`timescale 1ns/100ps
interface tws_if;
  logic scl;
  logic sda;
  logic host_scl_out;
  logic host_scl_oe_n;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;

  // pull-up wins unless an enabled driver pulls low
  assign scl = host_scl_oe_n | host_scl_out;
  assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

  modport dev (
    input scl,
    input sda,
    output dev_sda_out,
    output dev_sda_oe_n
  );

  modport host (
    input sda,
    output host_scl_out,
    output host_scl_oe_n,
    output host_sda_out,
    output host_sda_oe_n
  );
endinterface

// file: design/tws_host.sv
// two-wire bus master that drives the serial clock toward the slave port
`timescale 1ns/100ps
module tws_host #(
  parameter int QTR = tws_pkg::QTR_CYC
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  tws_if.host bus,
  input wire logic cmd_valid_in,
  input wire logic cmd_start_in,
  input wire logic cmd_stop_in,
  input wire logic cmd_read_in,
  input wire logic cmd_nack_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_ack_out
);

  localparam int QW = $clog2(QTR + 1);

  ////////////////////////////////////////////////////////////////////////////
  // quarter-bit enable and data line sampling

  logic [QW-1:0] qcnt;
  logic tick;
  logic [2:0] sda_sync;
  logic sda_f;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      qcnt <= '0;
      tick <= 1'b0;
      sda_sync <= 3'h7;
      sda_f <= 1'b1;
    end else begin
      tick <= qcnt == QW'(QTR - 1);
      qcnt <= (qcnt == QW'(QTR - 1)) ? '0 : qcnt + QW'(1);
      sda_sync <= {sda_sync[1:0], bus.sda};
      if (sda_sync[2] == sda_sync[1]) begin
        sda_f <= sda_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer

  tws_pkg::tws_host_state_t state;
  logic [1:0] ph;
  logic [3:0] bit_idx;
  logic [7:0] sh;
  logic rd;
  logic nack;
  logic stop_f;
  logic scl_oe_n;
  logic sda_oe_n;

  wire accept = cmd_valid_in & cmd_ready_out;
  // release during ack slot unless acknowledging a read
  wire ack_drive = rd ? nack : 1'b1;
  wire data_drive = rd ? 1'b1 : sh[7];
  wire bit_drive = bit_idx == tws_pkg::ACK_SLOT ? ack_drive : data_drive;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= tws_pkg::TWS_H_IDLE;
      ph <= tws_pkg::PH_DRIVE;
      bit_idx <= '0;
      sh <= '0;
      rd <= 1'b0;
      nack <= 1'b1;
      stop_f <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      cmd_ready_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= '0;
      rsp_ack_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      if (accept) begin
        state <= (cmd_start_in || state == tws_pkg::TWS_H_IDLE) ?
                 tws_pkg::TWS_H_START : tws_pkg::TWS_H_BIT;
        ph <= tws_pkg::PH_DRIVE;
        bit_idx <= '0;
        sh <= cmd_data_in;
        rd <= cmd_read_in;
        nack <= cmd_nack_in;
        stop_f <= cmd_stop_in;
        cmd_ready_out <= 1'b0;
      end else if (tick) begin
        ph <= ph + 2'h1;
        case (state)
          tws_pkg::TWS_H_START: begin
            case (ph)
              tws_pkg::PH_DRIVE: sda_oe_n <= 1'b1;
              tws_pkg::PH_RISE: scl_oe_n <= 1'b1;
              tws_pkg::PH_SAMPLE: sda_oe_n <= 1'b0;
              default: begin
                scl_oe_n <= 1'b0;
                state <= tws_pkg::TWS_H_BIT;
              end
            endcase
          end
          tws_pkg::TWS_H_BIT: begin
            case (ph)
              tws_pkg::PH_DRIVE: sda_oe_n <= bit_drive;
              tws_pkg::PH_RISE: scl_oe_n <= 1'b1;
              tws_pkg::PH_SAMPLE: begin
                if (bit_idx == tws_pkg::ACK_SLOT) begin
                  rsp_ack_out <= ~sda_f;
                end else begin
                  sh <= {sh[6:0], sda_f};
                end
              end
              default: begin
                scl_oe_n <= 1'b0;
                if (bit_idx == tws_pkg::ACK_SLOT) begin
                  rsp_valid_out <= 1'b1;
                  rsp_data_out <= sh;
                  state <= stop_f ? tws_pkg::TWS_H_STOP : tws_pkg::TWS_H_HOLD;
                  cmd_ready_out <= ~stop_f;
                end else begin
                  bit_idx <= bit_idx + 4'h1;
                end
              end
            endcase
          end
          tws_pkg::TWS_H_STOP: begin
            case (ph)
              tws_pkg::PH_DRIVE: sda_oe_n <= 1'b0;
              tws_pkg::PH_RISE: scl_oe_n <= 1'b1;
              tws_pkg::PH_SAMPLE: sda_oe_n <= 1'b1;
              default: begin
                state <= tws_pkg::TWS_H_IDLE;
                cmd_ready_out <= 1'b1;
              end
            endcase
          end
          default: begin
            ph <= tws_pkg::PH_DRIVE;
          end
        endcase
      end
    end
  end

  assign bus.host_scl_oe_n = scl_oe_n;
  assign bus.host_sda_oe_n = sda_oe_n;
  assign bus.host_scl_out = 1'b0;
  assign bus.host_sda_out = 1'b0;

endmodule

// file: tb/tws_properties.sv
// concurrent checks on the two-wire bus between the master and the slave port
`timescale 1ns/100ps
module tws_properties #(
  parameter logic [6:0] OWN_ADDR = tws_pkg::OWN_ADDR_DEF
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n
);
  logic pscl, psda, inf, byte0, rd, fgn;
  logic [3:0] bitn;
  logic [7:0] sh;
  wire start_now = scl & pscl & psda & ~sda;
  wire stop_now = scl & pscl & ~psda & sda;
  wire rise = scl & ~pscl;
  wire at_ack = rise & (bitn == 4'h8);
  wire foreign = sh[7:1] != OWN_ADDR;
  wire next_inf = start_now | (inf & ~stop_now);
  wire [3:0] bit_inc = (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
  wire [3:0] next_bitn = start_now ? 4'h0 : (rise ? bit_inc : bitn);
  wire next_byte0 = start_now | (byte0 & ~(rise & (bitn == 4'h9)));
  wire [7:0] next_sh = (rise & (bitn < 4'h8)) ? {sh[6:0], sda} : sh;
  wire next_rd = (rise & byte0 & (bitn == 4'h7)) ? sda : rd;
  // a stop alone does not wake the port, so only a start clears this
  wire next_fgn = ~start_now & (fgn | (byte0 & (bitn == 4'h8) & foreign));
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {pscl, psda, inf, byte0, rd, fgn, bitn, sh} <= {6'h30, 4'h0, 8'h00};
    end else begin
      {pscl, psda, inf, byte0, rd, fgn} <= {scl, sda, next_inf, next_byte0, next_rd, next_fgn};
      bitn <= next_bitn;
      sh <= next_sh;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  sequence s_dev_move;
    $changed(dev_sda_oe_n);
  endsequence
  sequence s_pull_high;
    scl && !dev_sda_oe_n;
  endsequence
  a_dev_move_low: assert property (s_dev_move |-> !scl)
    else $error("slave moved data with clock high");
  a_ack_held: assert property (s_pull_high |=> !scl || !dev_sda_oe_n)
    else $error("slave let go of data with clock high");
  a_ack_own: assert property (at_ack && byte0 && !foreign |-> !dev_sda_oe_n)
    else $error("own address not acknowledged");
  a_quiet_foreign: assert property (fgn |-> dev_sda_oe_n)
    else $error("slave drove after foreign address");
  a_addr_quiet: assert property (inf && byte0 && bitn < 4'h8 |-> dev_sda_oe_n)
    else $error("slave drove during address");
  a_rd_release: assert property (at_ack && !byte0 && rd |-> dev_sda_oe_n)
    else $error("slave held data in read ack slot");
  a_host_release: assert property (at_ack && (byte0 || !rd) |-> host_sda_oe_n)
    else $error("master held data in write ack slot");
  // the stop's own clock rise opens a would-be byte
  a_whole_bytes: assert property (stop_now && inf |-> bitn == 4'h1)
    else $error("frame ended off a nine-pulse boundary");
  a_idle_high: assert property (!inf && !start_now |-> scl && sda)
    else $error("lines not high outside a frame");
endmodule

// file: tb/test_pmu_two_wire_slave_port.sv
// bench: master and slave port on one bus, a hand-driven second bus for faults
`timescale 1ns/100ps
module test_pmu_two_wire_slave_port;
  typedef struct packed {
    logic st, sp, rd, nk;
    logic [7:0] d;
    logic tv;
    logic [7:0] td;
    logic ea;
    logic [7:0] ed;
  } tws_row_t;
  localparam int QTR = 8;
  localparam int HOLD = 4;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic cmd_valid = 1'b0;
  logic rx_ready = 1'b1;
  logic [1:0] bb = 2'h3;
  tws_row_t cur = '0;
  logic [8:0] wsh = 9'h000;
  logic tx_pend = 1'b0;
  logic [7:0] tx_data = 8'h00;
  wire [7:0] rx_data, rsp_data;
  wire rx_valid, tx_ready, busy, abort, cmd_ready, rsp_valid, rsp_ack, rv2, busy2, abort2;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0, k = 0, n_ab = 0, n_ab2 = 0, n_txr = 0;
  logic [7:0] q[$];
  logic [7:0] exp_q [5] = '{8'hA5, 8'h5A, 8'h00, 8'h11, 8'h22};
  logic [1:0] bbs [18] = '{2'h3, 2'h2, 2'h0, 2'h1, 2'h3, 2'h1, 2'h0, 2'h2, 2'h3,
                           2'h3, 2'h2, 2'h0, 2'h1, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3};
  tws_row_t rows [9] = '{{4'h8, 8'h78, 1'b0, 8'h00, 1'b1, 8'h78},
                         {4'h0, 8'hA5, 1'b0, 8'h00, 1'b1, 8'hA5},
                         {4'h4, 8'h5A, 1'b0, 8'h00, 1'b1, 8'h5A},
                         {4'h8, 8'h79, 1'b1, 8'hC3, 1'b1, 8'h79},
                         {4'h2, 8'h00, 1'b0, 8'h00, 1'b1, 8'hC3},
                         {4'h3, 8'h00, 1'b0, 8'h00, 1'b0, 8'hFF},
                         {4'hC, 8'h7A, 1'b0, 8'h00, 1'b0, 8'h7A},
                         {4'h8, 8'h78, 1'b0, 8'h00, 1'b1, 8'h78},
                         {4'h4, 8'h00, 1'b0, 8'h00, 1'b1, 8'h00}};
  tws_row_t full [4] = '{{4'h8, 8'h78, 1'b0, 8'h00, 1'b1, 8'h78},
                         {4'h0, 8'h11, 1'b0, 8'h00, 1'b1, 8'h11},
                         {4'h0, 8'h22, 1'b0, 8'h00, 1'b1, 8'h22},
                         {4'h4, 8'h33, 1'b0, 8'h00, 1'b0, 8'h33}};
  tws_if tws_if_i ();
  tws_if tws_if_i2 ();
  assign tws_if_i2.host_scl_out = 1'b0;
  assign tws_if_i2.host_sda_out = 1'b0;
  assign tws_if_i2.host_scl_oe_n = bb[1];
  assign tws_if_i2.host_sda_oe_n = bb[0];
  tws_host #(.QTR(QTR)) tws_host_i (.clk_in(clk_in), .nrst_in(nrst_in), .bus(tws_if_i),
    .cmd_valid_in(cmd_valid), .cmd_start_in(cur.st), .cmd_stop_in(cur.sp),
    .cmd_read_in(cur.rd), .cmd_nack_in(cur.nk), .cmd_data_in(cur.d), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .rsp_ack_out(rsp_ack));
  tws_device #(.BUSY_HOLD(HOLD)) tws_device_i (.clk_in(clk_in), .nrst_in(nrst_in),
    .bus(tws_if_i), .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
    .tx_data_in(tx_data), .tx_valid_in(tx_pend), .tx_ready_out(tx_ready), .busy_out(busy),
    .abort_out(abort));
  tws_device #(.BUSY_HOLD(HOLD)) tws_device_i2 (.clk_in(clk_in), .nrst_in(nrst_in),
    .bus(tws_if_i2), .rx_data_out(), .rx_valid_out(rv2), .rx_ready_in(1'b1),
    .tx_data_in(8'h00), .tx_valid_in(1'b0), .tx_ready_out(), .busy_out(busy2),
    .abort_out(abort2));
  tws_properties tws_properties_i (.clk_in(clk_in), .nrst_in(nrst_in), .scl(tws_if_i.scl),
    .sda(tws_if_i.sda), .host_sda_oe_n(tws_if_i.host_sda_oe_n),
    .dev_sda_oe_n(tws_if_i.dev_sda_oe_n));
  ////////////////////////////////////////////////////////////
  always #10 clk_in = ~clk_in;
  always @(posedge tws_if_i.scl) wsh <= {wsh[7:0], tws_if_i.sda};
  // read byte stays offered until the port takes it, past the row that armed it
  always @(posedge clk_in) begin
    if (tx_ready === 1'b1) tx_pend <= 1'b0;
    else if (cur.tv) begin
      tx_pend <= 1'b1;
      tx_data <= cur.td;
    end
  end
  always @(negedge clk_in) begin
    if (rx_valid === 1'b1 && rx_ready) q.push_back(rx_data);
    n_ab += (abort === 1'b1);
    n_ab2 += (abort2 === 1'b1);
    n_txr += (tx_ready === 1'b1);
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task wrap_up;
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_checks++;
    if (!ok) begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  // one byte command, held until taken, then the answer at the ninth pulse
  task run(input tws_row_t r);
    @(posedge clk_in);
    cur <= r;
    cmd_valid <= 1'b1;
    k = 0;
    @(negedge clk_in);
    while (cmd_ready !== 1'b1 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (rsp_valid !== 1'b1 && k < 3000);
    chk(rsp_ack === r.ea, "ack bit");
    chk(rsp_data === r.ed && wsh === {r.ed, ~r.ea}, "byte on wire");
    if (r.sp) begin
      repeat (6 * QTR + HOLD + 12) @(negedge clk_in);
      chk(busy === 1'b0 && tws_if_i.scl === 1'b1 && tws_if_i.sda === 1'b1, "idle");
    end else chk(busy === 1'b1, "busy in frame");
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(negedge clk_in);
    chk(busy === 1'b0 && rx_valid === 1'b0 && cmd_ready === 1'b1 && tws_if_i.sda === 1'b1, "rst");
    foreach (rows[i]) run(rows[i]);
    chk(n_txr == 1, "tx taken count");
    // stalled reader: the byte after two must be refused, nothing lost
    @(posedge clk_in);
    rx_ready <= 1'b0;
    foreach (full[i]) run(full[i]);
    chk(rx_valid === 1'b1 && rx_data === 8'h11, "stalled head");
    @(posedge clk_in);
    rx_ready <= 1'b1;
    repeat (4) @(negedge clk_in);
    chk(rx_valid === 1'b0 && q.size() == 5, "drain");
    foreach (exp_q[i]) chk(q[i] === exp_q[i], "rx byte");
    // second bus: stop and restart dropped after two bits on purpose
    foreach (bbs[i]) begin
      @(posedge clk_in);
      bb <= bbs[i];
      repeat (16) @(posedge clk_in);
    end
    @(negedge clk_in);
    chk(n_ab2 == 2 && n_ab == 0 && busy2 === 1'b0 && rv2 === 1'b0, "fault bus");
    wrap_up();
  end
endmodule
